//--- rtl/lsq_consts.svh
`ifndef LSQ_CONSTS_SVH
`define LSQ_CONSTS_SVH

// register offsets, reset key and reset value
`define LSQ_ADDR_ENABLE   8'h00
`define LSQ_ADDR_OPMODE   8'h01
`define LSQ_ADDR_CONFIG   8'h08
`define LSQ_ADDR_STATUS   8'h0C
`define LSQ_ADDR_RESET    8'h0D
`define LSQ_ADDR_MEM_LO   8'h10
`define LSQ_ADDR_MEM_HI   8'h2F
`define LSQ_RESET_KEY     8'hFF
`define LSQ_REG_RESET     8'h00

// field positions
`define LSQ_CHIP_EN_BIT   6
`define LSQ_AUTO_PS_BIT   5
`define LSQ_DET_EN_BIT    1
`define LSQ_EXT_USED_BIT  0

// timing
`define LSQ_CLK_HZ        200000000
`define LSQ_SEQ_HZ        32768
`define LSQ_PIN_SU_US     1000
`define LSQ_BIT_SU_US     500
`define LSQ_DET_MIN_HZ    4000
`define LSQ_PS_SHORT_MS   50
`define LSQ_PS_LONG_MS    80
`define LSQ_TRIG_TICKS    5'h10
`define LSQ_PRE_SLOW_SH   9
`define LSQ_PRE_FAST_SH   4

`endif

//--- rtl/lsq_pkg.sv
package lsq_pkg;
	// device operating mode
	typedef enum logic [2:0]
	{
		LSQ_STANDBY = 3'b001,
		LSQ_STARTUP = 3'b010,
		LSQ_NORMAL  = 3'b100
	} lsq_mode_e;

	// what one engine is executing now
	typedef struct packed
	{
		logic [15:0] cmd;
		logic [15:0] next_cmd;
		logic [7:0]  pwm;
		logic [21:0] left;
	} lsq_eng_s;

	typedef lsq_eng_s [2:0] lsq_eng_arr_t;

	// one byte access from the serial interface
	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lsq_req_s;
endpackage : lsq_pkg

//--- rtl/lsq_ctrl.sv
`timescale 1ns/1ps
`include "lsq_consts.svh"
module lsq_ctrl
#(
	parameter int PIN_SU_CYC = `LSQ_PIN_SU_US * (`LSQ_CLK_HZ / 1000000),
	parameter int BIT_SU_CYC = `LSQ_BIT_SU_US * (`LSQ_CLK_HZ / 1000000),
	parameter int OSC_DIV    = `LSQ_CLK_HZ / `LSQ_SEQ_HZ,
	parameter int DET_CYC    = `LSQ_CLK_HZ / `LSQ_DET_MIN_HZ
)
(
	input  wire logic                clk_in,          // 200 MHz
	input  wire logic                rst_in,          // power-on reset
	input  wire logic                enable_pin_in,   // enable pin, async
	input  wire logic                slow_clock_pin_in, // external 32 kHz, async
	input  wire logic                overheat_cutoff_in, // thermal flag, async
	input  wire lsq_pkg::lsq_req_s   req_in,          // register access
	input  wire lsq_pkg::lsq_eng_arr_t eng_in,        // engine status
	input  wire logic [2:0]          eng_exec_in,     // instruction start pulses
	output logic [7:0]               reg_rdata_out,   // read data
	output lsq_pkg::lsq_mode_e       mode_out,        // device mode
	output logic [5:0]               op_modes_out,    // effective engine modes
	output logic [5:0]               exec_modes_out,  // effective exec bits
	output logic                     seq_tick_out,    // sequencer clock tick
	output logic                     power_save_out,  // in power save
	output logic                     leds_on_out,     // led drivers powered
	output logic                     analog_on_out,   // analog blocks powered
	output logic [2:0]               trig_done_out    // trigger wait finished
);
	import lsq_pkg::*;

	localparam logic [21:0] PS_SHORT = 22'(`LSQ_PS_SHORT_MS * `LSQ_SEQ_HZ / 1000);
	localparam logic [21:0] PS_LONG  = 22'(`LSQ_PS_LONG_MS * `LSQ_SEQ_HZ / 1000);
	localparam logic [19:0] PIN_SU   = 20'(PIN_SU_CYC);
	localparam logic [19:0] BIT_SU   = 20'(BIT_SU_CYC);
	localparam logic [12:0] OSC_TOP  = 13'(OSC_DIV - 1);
	localparam logic [16:0] DET_TOP  = 17'(DET_CYC);

	// duration of a ramp step in master ticks, by prescale
	function automatic logic [21:0] step_ticks(input logic [15:0] c);
		step_ticks = c[14] ? (22'(c[13:8]) << `LSQ_PRE_SLOW_SH) : (22'(c[13:8]) << `LSQ_PRE_FAST_SH);
	endfunction : step_ticks

	// idle threshold for a command, longer with slow prescale
	function automatic logic [21:0] idle_limit(input logic [15:0] c);
		idle_limit = c[14] ? PS_LONG : PS_SHORT;
	endfunction : idle_limit

	// power save eligibility of one engine
	function automatic logic eng_ps_ok(input logic [1:0] m, input lsq_eng_s s);
		logic idle;
		idle = (s.pwm == 8'h00);
		eng_ps_ok = 1'b1;
		case (m)
			2'b00: eng_ps_ok = 1'b1;
			2'b01: eng_ps_ok = 1'b0;
			2'b11: eng_ps_ok = idle;
			default:
			begin
				if (s.cmd[15:13] == 3'b111)
					eng_ps_ok = idle;
				else if (s.cmd[15:13] == 3'b110)
					eng_ps_ok = idle || s.cmd[11];
				else if (!s.cmd[15] && s.cmd[13:8] == 6'h00 && s.cmd[14])
					eng_ps_ok = (s.cmd[7:0] == 8'h00) && (step_ticks(s.next_cmd) > PS_SHORT);
				else if (!s.cmd[15] && s.cmd[13:8] != 6'h00 && s.cmd[6:0] == 7'h00)
					eng_ps_ok = idle && (step_ticks(s.cmd) > idle_limit(s.cmd));
				else if (!s.cmd[15] && s.cmd[13:8] != 6'h00)
					eng_ps_ok = idle && (s.left > idle_limit(s.cmd));
				else
					eng_ps_ok = 1'b1;
			end
		endcase
	endfunction : eng_ps_ok

	// two-flop synchronisers for the pins
	logic [1:0] en_sync_reg;
	logic [2:0] slow_sync_reg;
	logic [1:0] hot_sync_reg;
	logic       pin_en;
	logic       hot;
	always_ff @(posedge clk_in)
	begin
		en_sync_reg   <= {en_sync_reg[0], enable_pin_in};
		slow_sync_reg <= {slow_sync_reg[1:0], slow_clock_pin_in};
		hot_sync_reg  <= {hot_sync_reg[0], overheat_cutoff_in};
	end
	assign pin_en = en_sync_reg[1];
	assign hot    = hot_sync_reg[1];

	// register, mode and start-up state
	logic [7:0]  ctrl_reg, ctrl_next;
	logic [7:0]  ops_reg, ops_next;
	logic [7:0]  cfg_reg, cfg_next;
	logic [7:0]  act_ctrl_reg, act_ctrl_next;
	logic [7:0]  act_ops_reg, act_ops_next;
	logic [7:0]  act_cfg_reg, act_cfg_next;
	logic [7:0]  mem_reg [32];
	logic [7:0]  mem_next [32];
	logic [7:0]  rdata_reg, rdata_next;
	lsq_mode_e   mode_reg, mode_next;
	logic [19:0] pin_cnt_reg, pin_cnt_next;
	logic [19:0] bit_cnt_reg, bit_cnt_next;
	logic        soft_rst;
	logic        ext_used;
	logic        wr_ok;

	assign soft_rst = req_in.wr && req_in.addr == `LSQ_ADDR_RESET && req_in.wdata == `LSQ_RESET_KEY;
	assign wr_ok    = req_in.wr && pin_en;

	// register writes, reads and the mode machine
	always_comb
	begin
		ctrl_next     = ctrl_reg;
		ops_next      = ops_reg;
		cfg_next      = cfg_reg;
		act_ctrl_next = act_ctrl_reg;
		act_ops_next  = act_ops_reg;
		act_cfg_next  = act_cfg_reg;
		mem_next      = mem_reg;
		rdata_next    = rdata_reg;
		mode_next     = mode_reg;
		pin_cnt_next  = !pin_en ? 20'h00000 : (pin_cnt_reg < PIN_SU ? pin_cnt_reg + 20'h00001 : pin_cnt_reg);
		bit_cnt_next  = !ctrl_reg[`LSQ_CHIP_EN_BIT] ? 20'h00000 :
			(bit_cnt_reg < BIT_SU ? bit_cnt_reg + 20'h00001 : bit_cnt_reg);
		if (wr_ok)
		begin
			if (req_in.addr == `LSQ_ADDR_ENABLE)
				ctrl_next = req_in.wdata;
			else if (req_in.addr == `LSQ_ADDR_OPMODE)
				ops_next = req_in.wdata;
			else if (req_in.addr == `LSQ_ADDR_CONFIG)
				cfg_next = req_in.wdata;
			else if (req_in.addr >= `LSQ_ADDR_MEM_LO && req_in.addr <= `LSQ_ADDR_MEM_HI && ops_reg[5:4] == 2'b01)
				mem_next[5'(req_in.addr - `LSQ_ADDR_MEM_LO)] = req_in.wdata;
		end
		if (req_in.rd)
		begin
			if (req_in.addr == `LSQ_ADDR_ENABLE)
				rdata_next = ctrl_reg;
			else if (req_in.addr == `LSQ_ADDR_OPMODE)
				rdata_next = ops_reg;
			else if (req_in.addr == `LSQ_ADDR_CONFIG)
				rdata_next = cfg_reg;
			else if (req_in.addr == `LSQ_ADDR_STATUS)
				rdata_next = {7'h00, ext_used};
			else if (req_in.addr >= `LSQ_ADDR_MEM_LO && req_in.addr <= `LSQ_ADDR_MEM_HI)
				rdata_next = mem_reg[5'(req_in.addr - `LSQ_ADDR_MEM_LO)];
			else
				rdata_next = 8'h00;
		end
		case (mode_reg)
			LSQ_STANDBY:
			begin
				if (ctrl_reg[`LSQ_CHIP_EN_BIT] && pin_en)
					mode_next = LSQ_STARTUP;
			end
			LSQ_STARTUP:
			begin
				if (!ctrl_reg[`LSQ_CHIP_EN_BIT] || !pin_en)
					mode_next = LSQ_STANDBY;
				else if (!hot && pin_cnt_reg >= PIN_SU && bit_cnt_reg >= BIT_SU)
					mode_next = LSQ_NORMAL;
			end
			LSQ_NORMAL:
			begin
				if (!pin_en)
				begin
					ctrl_next[`LSQ_CHIP_EN_BIT] = 1'b0;
					mode_next = LSQ_STANDBY;
				end
				else if (!ctrl_reg[`LSQ_CHIP_EN_BIT])
					mode_next = LSQ_STANDBY;
				else if (hot)
					mode_next = LSQ_STARTUP;
				act_ctrl_next = ctrl_reg;
				act_ops_next  = ops_reg;
				act_cfg_next  = cfg_reg;
			end
			default: mode_next = LSQ_STANDBY;
		endcase
		if (mode_reg != LSQ_NORMAL && mode_next == LSQ_NORMAL)
		begin
			act_ctrl_next = ctrl_reg;
			act_ops_next  = ops_reg;
			act_cfg_next  = cfg_reg;
		end
		if (rst_in || soft_rst)
		begin
			ctrl_next     = `LSQ_REG_RESET;
			ops_next      = `LSQ_REG_RESET;
			cfg_next      = `LSQ_REG_RESET;
			act_ctrl_next = `LSQ_REG_RESET;
			act_ops_next  = `LSQ_REG_RESET;
			act_cfg_next  = `LSQ_REG_RESET;
			rdata_next    = 8'h00;
			mode_next     = LSQ_STANDBY;
			pin_cnt_next  = 20'h00000;
			bit_cnt_next  = 20'h00000;
			for (int i = 0; i < 32; i++)
				mem_next[i] = `LSQ_REG_RESET;
		end
	end

	always_ff @(posedge clk_in)
	begin
		ctrl_reg     <= ctrl_next;
		ops_reg      <= ops_next;
		cfg_reg      <= cfg_next;
		act_ctrl_reg <= act_ctrl_next;
		act_ops_reg  <= act_ops_next;
		act_cfg_reg  <= act_cfg_next;
		mem_reg      <= mem_next;
		rdata_reg    <= rdata_next;
		mode_reg     <= mode_next;
		pin_cnt_reg  <= pin_cnt_next;
		bit_cnt_reg  <= bit_cnt_next;
	end

	// clock source, detection and sequencer tick
	logic [12:0] osc_cnt_reg, osc_cnt_next;
	logic [16:0] det_cnt_reg, det_cnt_next;
	logic        tick_reg, tick_next;
	logic        ext_edge;
	logic        ext_present;
	logic        use_ext;

	assign ext_edge    = slow_sync_reg[1] && !slow_sync_reg[2];
	assign ext_present = det_cnt_reg < DET_TOP;
	assign ext_used    = cfg_reg[`LSQ_DET_EN_BIT] && ext_present;
	assign use_ext     = (act_cfg_reg[1:0] == 2'b00) || (act_cfg_reg[1:0] == 2'b10 && ext_present);

	always_comb
	begin
		osc_cnt_next = (osc_cnt_reg == OSC_TOP) ? 13'h0000 : osc_cnt_reg + 13'h0001;
		det_cnt_next = ext_edge ? 17'h00000 : (ext_present ? det_cnt_reg + 17'h00001 : det_cnt_reg);
		tick_next    = use_ext ? ext_edge : (osc_cnt_reg == OSC_TOP);
		if (rst_in)
		begin
			osc_cnt_next = 13'h0000;
			det_cnt_next = DET_TOP;
			tick_next    = 1'b0;
		end
	end

	always_ff @(posedge clk_in)
	begin
		osc_cnt_reg <= osc_cnt_next;
		det_cnt_reg <= det_cnt_next;
		tick_reg    <= tick_next;
	end

	// trigger posting, latching and wait completion
	logic [2:0] rx_reg [3];
	logic [2:0] rx_next [3];
	logic [2:0] wmask_reg [3];
	logic [2:0] wmask_next [3];
	logic [4:0] wcnt_reg [3];
	logic [4:0] wcnt_next [3];
	logic [2:0] done_reg, done_next;

	always_comb
	begin
		rx_next    = rx_reg;
		wmask_next = wmask_reg;
		wcnt_next  = wcnt_reg;
		done_next  = 3'h0;
		// finished waits clear their latched triggers first
		for (int e = 0; e < 3; e++)
		begin
			if (tick_reg && wmask_reg[e] != 3'h0 && wcnt_reg[e] < `LSQ_TRIG_TICKS)
				wcnt_next[e] = wcnt_reg[e] + 5'h01;
			if (wmask_reg[e] != 3'h0 && wcnt_reg[e] >= `LSQ_TRIG_TICKS && (rx_reg[e] & wmask_reg[e]) == wmask_reg[e])
			begin
				rx_next[e]    = rx_reg[e] & ~wmask_reg[e];
				wmask_next[e] = 3'h0;
				done_next[e]  = 1'b1;
			end
		end
		// new sends win over a clear in the same cycle
		for (int e = 0; e < 3; e++)
		begin
			if (eng_exec_in[e] && eng_in[e].cmd[15:13] == 3'b111)
			begin
				for (int d = 0; d < 3; d++)
					if (eng_in[e].cmd[1 + d])
						rx_next[d][e] = 1'b1;
				wmask_next[e] = eng_in[e].cmd[9:7];
				wcnt_next[e]  = 5'h00;
			end
		end
		if (rst_in || soft_rst)
		begin
			for (int e = 0; e < 3; e++)
			begin
				rx_next[e]    = 3'h0;
				wmask_next[e] = 3'h0;
				wcnt_next[e]  = 5'h00;
			end
			done_next = 3'h0;
		end
	end

	always_ff @(posedge clk_in)
	begin
		rx_reg    <= rx_next;
		wmask_reg <= wmask_next;
		wcnt_reg  <= wcnt_next;
		done_reg  <= done_next;
	end

	// power save look-ahead and power domain outputs
	logic       ps_reg, ps_next;
	logic       leds_reg, leds_next;
	logic       analog_reg, analog_next;
	logic       all_ok;

	assign all_ok = eng_ps_ok(act_ops_reg[5:4], eng_in[0]) && eng_ps_ok(act_ops_reg[3:2], eng_in[1])
		&& eng_ps_ok(act_ops_reg[1:0], eng_in[2]);

	always_comb
	begin
		ps_next = ps_reg;
		if (tick_reg || eng_exec_in != 3'h0)
			ps_next = all_ok && act_cfg_reg[`LSQ_AUTO_PS_BIT];
		if (!all_ok || !act_cfg_reg[`LSQ_AUTO_PS_BIT])
			ps_next = 1'b0;
		if (mode_next != LSQ_NORMAL)
			ps_next = 1'b0;
		leds_next   = (mode_next == LSQ_NORMAL) && !ps_next;
		analog_next = (mode_next != LSQ_STANDBY) && !(ps_next && use_ext);
		if (rst_in || soft_rst)
		begin
			ps_next     = 1'b0;
			leds_next   = 1'b0;
			analog_next = 1'b0;
		end
	end

	always_ff @(posedge clk_in)
	begin
		ps_reg     <= ps_next;
		leds_reg   <= leds_next;
		analog_reg <= analog_next;
	end

	// outputs straight from flops
	assign reg_rdata_out  = rdata_reg;
	assign mode_out       = mode_reg;
	assign op_modes_out   = act_ops_reg[5:0];
	assign exec_modes_out = act_ctrl_reg[5:0];
	assign seq_tick_out   = tick_reg;
	assign power_save_out = ps_reg;
	assign leds_on_out    = leds_reg;
	assign analog_on_out  = analog_reg;
	assign trig_done_out  = done_reg;
endmodule : lsq_ctrl

//--- verif/lsq_clk_src.sv
`timescale 1ns/1ps
// external slow clock source at the slow clock pin
module lsq_clk_src
(
	input  wire logic [1:0] mode_in, // 0 runs, 1 stuck low, 2 stuck high
	input  wire logic [9:0] half_in, // half period in ns
	output logic            clk_out  // slow clock pin level
);
	// free running phase, unrelated to the system clock
	initial
	begin
		clk_out = 1'b0;
		#3.3;
		forever
		begin
			#(half_in);
			clk_out = (mode_in == 2'h0) ? ~clk_out : (mode_in == 2'h2);
		end
	end
endmodule : lsq_clk_src

//--- verif/lsq_ctrl_checker.sv
`timescale 1ns/1ps
// port level checks on the control block
module lsq_ctrl_checker
import lsq_pkg::*;
#(
	parameter int BIT_SU_CYC = 20
)
(
	input wire logic                  clk_in,             // clock
	input wire logic                  rst_in,             // reset
	input wire logic                  enable_pin_in,      // enable pin
	input wire logic                  overheat_cutoff_in, // thermal flag
	input wire lsq_pkg::lsq_req_s     req_in,             // register access
	input wire lsq_pkg::lsq_eng_arr_t eng_in,             // engine status
	input wire logic [2:0]            eng_exec_in,        // exec pulses
	input wire logic [7:0]            reg_rdata_out,      // read data
	input wire lsq_pkg::lsq_mode_e    mode_out,           // device mode
	input wire logic                  seq_tick_out,       // master tick
	input wire logic                  power_save_out,     // power save
	input wire logic                  leds_on_out,        // led drivers on
	input wire logic                  analog_on_out,      // analog on
	input wire logic [2:0]            trig_done_out       // wait done
);
	logic [4:0] tcnt [3];
	int         su_cnt;

	// ticks since each trigger start, cycles out of standby
	always_ff @(posedge clk_in)
	begin
		for (int e = 0; e < 3; e++)
			if (rst_in || (eng_exec_in[e] && eng_in[e].cmd[15:13] == 3'h7))
				tcnt[e] <= 5'h00;
			else if (seq_tick_out && tcnt[e] != 5'h1F)
				tcnt[e] <= tcnt[e] + 5'h01;
		su_cnt <= (rst_in || mode_out == LSQ_STANDBY) ? 0 : su_cnt + 1;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_hot; overheat_cutoff_in [*5]; endsequence
	sequence s_pin_drop; (mode_out == LSQ_NORMAL && !enable_pin_in) ##1 !enable_pin_in [*4]; endsequence

	property p_leds; leds_on_out |-> !power_save_out; endproperty
	property p_standby; (mode_out == LSQ_STANDBY) [*2] |-> !leds_on_out && !analog_on_out; endproperty
	property p_ps_mode; (mode_out != LSQ_NORMAL) [*2] |-> !power_save_out; endproperty
	property p_rst; $fell(rst_in) |-> mode_out == LSQ_STANDBY && trig_done_out == 3'h0; endproperty
	property p_hot; s_hot |-> mode_out != LSQ_NORMAL; endproperty
	property p_pin; s_pin_drop |-> mode_out == LSQ_STANDBY; endproperty
	property p_su; $rose(mode_out == LSQ_NORMAL) |-> su_cnt >= BIT_SU_CYC - 4; endproperty
	property p_trig; trig_done_out != 3'h0 |-> (trig_done_out & ~{tcnt[2][4], tcnt[1][4], tcnt[0][4]}) == 3'h0;
	endproperty
	property p_tick; seq_tick_out |=> !seq_tick_out; endproperty
	property p_rd0d; req_in.rd && req_in.addr == 8'h0D |=> reg_rdata_out == 8'h00; endproperty

	a_leds: assert property (p_leds) else $error("leds on in power save");
	a_standby: assert property (p_standby) else $error("power on in standby");
	a_ps_mode: assert property (p_ps_mode) else $error("power save outside normal");
	a_rst: assert property (p_rst) else $error("bad state after reset");
	a_hot: assert property (p_hot) else $error("normal while overheated");
	a_pin: assert property (p_pin) else $error("pin low kept normal");
	a_su: assert property (p_su) else $error("start-up too short");
	a_trig: assert property (p_trig) else $error("trigger wait ended early");
	a_tick: assert property (p_tick) else $error("tick longer than one cycle");
	a_rd0d: assert property (p_rd0d) else $error("reset register readable");
endmodule : lsq_ctrl_checker

bind lsq_ctrl lsq_ctrl_checker #(.BIT_SU_CYC(BIT_SU_CYC)) lsq_ctrl_checker_inst (.clk_in, .rst_in, .enable_pin_in,
	.overheat_cutoff_in, .req_in, .eng_in, .eng_exec_in, .reg_rdata_out, .mode_out, .seq_tick_out, .power_save_out,
	.leds_on_out, .analog_on_out, .trig_done_out);

//--- verif/lsq_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module lsq_ctrl_test;
	import lsq_pkg::*;
	logic         clk_in = 1'b0;
	logic         rst_in = 1'b1;
	logic         pin = 1'b1;
	logic         hot = 1'b0;
	logic         slow, tick, ps, leds, ana, rd_d;
	logic [1:0]   src_mode = 2'h0;
	logic [9:0]   src_half = 10'h064;
	lsq_req_s     req = '0;
	lsq_eng_arr_t eng = '0;
	logic [2:0]   ex = 3'h0;
	logic [2:0]   tdone, seen;
	logic [7:0]   rdata, exp_v;
	logic [15:0]  dc;
	lsq_mode_e    mode;
	logic [5:0]   opm;
	logic [5:0]   exm;
	logic [7:0]   expq[$];
	int           errors = 0, n_compared = 0, cyc = 0, n;
	// cmd, next cmd, pwm, ticks left, power save expected
	logic [62:0]  tbl[12] = '{{16'h4600, 16'h0, 8'h0, 22'h0, 1'b1}, {16'h3F00, 16'h0, 8'h0, 22'h0, 1'b0},
		{16'hD800, 16'h0, 8'h5, 22'h0, 1'b1}, {16'hC000, 16'h0, 8'h5, 22'h0, 1'b0},
		{16'h4000, 16'h7F00, 8'h0, 22'h0, 1'b1}, {16'h4000, 16'h4100, 8'h0, 22'h0, 1'b0},
		{16'h0181, 16'h0, 8'h0, 22'h700, 1'b1}, {16'h0181, 16'h0, 8'h0, 22'h600, 1'b0},
		{16'h4600, 16'h0, 8'h0, 22'h0, 1'b1}, {16'h4400, 16'h0, 8'h0, 22'h0, 1'b0},
		{16'hE080, 16'h0, 8'h0, 22'h0, 1'b1}, {16'h4181, 16'h0, 8'h0, 22'h700, 1'b0}};

	always #2.5 clk_in = ~clk_in;

	lsq_ctrl #(.PIN_SU_CYC(40), .BIT_SU_CYC(20), .OSC_DIV(8), .DET_CYC(64)) lsq_ctrl_inst (.clk_in(clk_in),
		.rst_in(rst_in), .enable_pin_in(pin), .slow_clock_pin_in(slow), .overheat_cutoff_in(hot), .req_in(req),
		.eng_in(eng), .eng_exec_in(ex), .reg_rdata_out(rdata), .mode_out(mode), .op_modes_out(opm),
		.exec_modes_out(exm), .seq_tick_out(tick), .power_save_out(ps), .leds_on_out(leds), .analog_on_out(ana),
		.trig_done_out(tdone));
	lsq_clk_src lsq_clk_src_inst (.mode_in(src_mode), .half_in(src_half), .clk_out(slow));

	// read results against the oldest note, and the hang limit
	always @(posedge clk_in)
	begin
		rd_d <= req.rd;
		cyc <= cyc + 1;
		if (rd_d === 1'b1)
		begin
			exp_v = expq.pop_front();
			`CHK(rdata, exp_v)
		end
		if (cyc == 20000)
		begin
			errors++;
			end_sim();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge clk_in);
		req.wr <= 1'b0;
		@(posedge clk_in);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		req.rd <= 1'b1;
		req.addr <= a;
		expq.push_back(e);
		@(posedge clk_in);
		req.rd <= 1'b0;
		@(posedge clk_in);
	endtask : rd

	task automatic wait_mode(input lsq_mode_e m);
		for (n = 0; n < 300 && mode !== m; n++)
			@(posedge clk_in);
		`CHK(mode, m)
	endtask : wait_mode

	// power save, leds, analog
	task automatic wait_pla(input logic [2:0] v);
		for (n = 0; n < 300 && {ps, leds, ana} !== v; n++)
			@(posedge clk_in);
		`CHK({ps, leds, ana}, v)
	endtask : wait_pla

	task automatic run_cmd(input logic [62:0] t);
		{eng[0].cmd, eng[0].next_cmd, eng[0].pwm, eng[0].left} <= t[62:1];
		ex <= 3'h1;
		@(posedge clk_in);
		ex <= 3'h0;
		wait_pla(t[0] ? 3'h5 : 3'h3);
	endtask : run_cmd

	task automatic trig_run(input logic [2:0] exs, input logic [2:0] e);
		seen = 3'h0;
		ex <= exs;
		@(posedge clk_in);
		ex <= 3'h0;
		repeat (400)
		begin
			@(posedge clk_in);
			seen |= tdone;
		end
		`CHK(seen, e)
	endtask : trig_run

	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	// main sequence
	initial
	begin
		n = $urandom(32'hF7E2);
		dc = 16'($urandom) & 16'h1C71;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		foreach (tbl[i])
			if (i < 5)
				rd(8'(i * 4 + (i > 2 ? 1 : 0)) | (i == 1 ? 8'h01 : 8'h00), 8'h00);
		rd(8'($urandom_range(255, 48)), 8'h00);
		rd(8'h0D, 8'h00);
		`CHK(mode, LSQ_STANDBY)
		wr(8'h01, 8'h10);
		wr(8'h00, 8'h4A);
		`CHK(opm, 6'h00)
		`CHK(exm, 6'h00)
		wait_mode(LSQ_STARTUP);
		wait_mode(LSQ_NORMAL);
		@(posedge clk_in);
		`CHK(opm, 6'h10)
		`CHK(exm, 6'h0A)
		// tick rate per clock source code, external at 200 ns
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h08, 8'(i));
			n = 0;
			repeat (400)
			begin
				@(posedge clk_in);
				n += int'(tick);
			end
			`CHK(i % 2 ? (n >= 48 && n <= 51) : (n >= 9 && n <= 11), 1'b1)
		end
		wr(8'h08, 8'h00);
		rd(8'h0C, 8'h00);
		wr(8'h08, 8'h02);
		// fast run, stuck low, run, stuck high
		for (int i = 0; i < 4; i++)
		begin
			src_mode <= (i % 2) ? 2'(i / 2 + 1) : 2'h0;
			src_half <= (i == 0) ? 10'h014 : 10'h064;
			repeat (200) @(posedge clk_in);
			rd(8'h0C, (i % 2) ? 8'h00 : 8'h01);
		end
		src_mode <= 2'h0;
		wr(8'h01, 8'h00);
		wr(8'h08, 8'h21);
		wait_pla(3'h5);
		wr(8'h08, 8'h22);
		wait_pla(3'h4);
		wr(8'h08, 8'h01);
		wait_pla(3'h3);
		wr(8'h08, 8'h21);
		wr(8'h01, 8'h10);
		wait_pla(3'h3);
		wr(8'h01, 8'h30);
		wait_pla(3'h5);
		eng[0].pwm <= 8'h05;
		wait_pla(3'h3);
		eng[0].pwm <= 8'h00;
		wait_pla(3'h5);
		wr(8'h01, 8'h34);
		wait_pla(3'h3);
		wr(8'h01, 8'h20);
		foreach (tbl[i])
			run_cmd(tbl[i]);
		// one sends to two, three waits for a trigger never sent
		eng[0].cmd <= 16'hE004 | dc;
		eng[1].cmd <= 16'hE080 | dc;
		eng[2].cmd <= 16'hE100 | dc;
		trig_run(3'h7, 3'h2);
		trig_run(3'h2, 3'h0);
		eng[0].cmd <= 16'hE00C | dc;
		eng[2].cmd <= 16'hE080 | dc;
		trig_run(3'h5, 3'h6);
		hot <= 1'b1;
		wait_mode(LSQ_STARTUP);
		// keep the fault up long enough to prove start-up is held
		repeat (8) @(posedge clk_in);
		`CHK(mode, LSQ_STARTUP)
		hot <= 1'b0;
		wait_mode(LSQ_NORMAL);
		pin <= 1'b0;
		wait_mode(LSQ_STANDBY);
		wr(8'h01, 8'h3F);
		pin <= 1'b1;
		rd(8'h00, 8'h0A);
		rd(8'h01, 8'h20);
		wr(8'h0D, 8'hFF);
		rd(8'h08, 8'h00);
		rd(8'h01, 8'h00);
		`CHK(exm, 6'h00)
		repeat (4) @(posedge clk_in);
		end_sim();
	end
endmodule : lsq_ctrl_test
